/* File: crts_pkg.sv */
// package for the sensor readout timing sequencer: constants, types and operation summary
// Operation
// - falling vertical phase one moves row down
// - leading dummy row merges with first dark
// - last line gets mode minimum pixel counts
// - rising vertical edge leads or meets falling
// - last horizontal gate fall shifts one pixel
// - clock at least mode minimum pixels per row
// - substrate shutter pulse is optional
// - integration spans shutter fall to phase fall
// - fast dump gate discards unwanted lines
// - dump two lines, then read one normally
// - each pin driven by one of seven patterns
// - at least 2460 or 4920 lines per frame
package crts_pkg;
    localparam int PIX_QUAD      = 5292;   // minimum pixels per line, quad readout
    localparam int PIX_SINGLE    = 10572;  // minimum pixels per line, single readout
    localparam int LINES_QUAD    = 2460;   // minimum lines per frame, quad readout
    localparam int LINES_SINGLE  = 4920;   // minimum lines per frame, single readout
    localparam int DUMP_LINES    = 2;      // lines discarded per dump group
    localparam int CNT_W         = 14;     // width of pixel and line counters
    localparam int VPH_CYC       = 4;      // cycles per vertical pattern step
    localparam int SHUT_CYC      = 4;      // cycles of substrate shutter pulse

    typedef enum logic [2:0] {
        CRTS_IDLE  = 3'b000,
        CRTS_SHUT  = 3'b001,
        CRTS_VXFER = 3'b011,
        CRTS_HREAD = 3'b010,
        CRTS_DUMP  = 3'b111
    } crts_state_t;
endpackage : crts_pkg

/* File: crts_if.sv */
// interface joining the timing generator to the sensor model
`timescale 1ns/1ps
`default_nettype none
interface crts_if;
    logic       vertical_phase_one;   // pattern one vertical clock
    logic       vertical_phase_four;  // pattern four vertical clock
    logic       last_horizontal_gate; // pattern six horizontal clock
    logic       sub_shutter;          // substrate shutter pulse
    logic       fast_dump_gate;       // fast line dump gate
    modport gen (output vertical_phase_one, vertical_phase_four, last_horizontal_gate,
                 sub_shutter, fast_dump_gate);
    modport sensor (input vertical_phase_one, vertical_phase_four, last_horizontal_gate,
                    sub_shutter, fast_dump_gate);
endinterface : crts_if
`default_nettype wire

/* File: crts_sensor.sv */
// sensor end: row transfer, pixel shifting, dump and integration tracking
`timescale 1ns/1ps
`default_nettype none
module crts_sensor
    import crts_pkg::*;
(
    input  wire logic             mclk,          // system clock
    input  wire logic             sys_rst,       // sync reset, active high
    input  wire logic             clk_en,        // freezes all state when low
    crts_if.sensor                lnk,           // pins from the generator
    output logic                  row_moved_ff,  // pulse: row entered shift register
    output logic                  pix_out_ff,    // pulse: one pixel shifted out
    output logic                  line_dumped_ff,// pulse: line discarded
    output logic [CNT_W-1:0]      row_cnt_ff,    // rows moved since reset
    output logic [CNT_W-1:0]      pix_cnt_ff,    // pixels out in current row
    output logic                  integ_ff,      // photodiodes integrating
    output logic [31:0]           integ_len_ff   // last integration length, cycles
);
    logic v1_q_ff;
    logic h_q_ff;
    logic sub_q_ff;
    logic v1_fall;
    logic h_fall;
    logic sub_fall;
    logic [31:0] integ_cnt_ff;

    // edge history; pins are synchronous so no synchroniser needed
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            v1_q_ff  <= 1'b0;
            h_q_ff   <= 1'b0;
            sub_q_ff <= 1'b0;
        end else if (clk_en) begin
            v1_q_ff  <= lnk.vertical_phase_one;
            h_q_ff   <= lnk.last_horizontal_gate;
            sub_q_ff <= lnk.sub_shutter;
        end
    end
    assign v1_fall  = v1_q_ff & ~lnk.vertical_phase_one;
    assign h_fall   = h_q_ff & ~lnk.last_horizontal_gate;
    assign sub_fall = sub_q_ff & ~lnk.sub_shutter;

    // row transfer on vertical fall; first move merges dummy and dark rows
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            row_moved_ff   <= 1'b0;
            line_dumped_ff <= 1'b0;
            row_cnt_ff     <= '0;
        end else if (clk_en) begin
            row_moved_ff   <= v1_fall & ~lnk.fast_dump_gate;
            line_dumped_ff <= v1_fall & lnk.fast_dump_gate;
            if (v1_fall && !lnk.fast_dump_gate && row_cnt_ff != 14'h3fff) begin
                row_cnt_ff <= row_cnt_ff + 14'h1; // dummy row folded into count 1
            end
        end
    end

    // pixel shift on last gate fall, count restarts per row
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_out_ff <= 1'b0;
            pix_cnt_ff <= '0;
        end else if (clk_en) begin
            pix_out_ff <= h_fall;
            if (v1_fall) begin
                pix_cnt_ff <= '0;
            end else if (h_fall && pix_cnt_ff != 14'h3fff) begin
                pix_cnt_ff <= pix_cnt_ff + 14'h1;
            end
        end
    end

    // integration window: shutter fall to next vertical fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            integ_ff     <= 1'b0;
            integ_cnt_ff <= '0;
            integ_len_ff <= '0;
        end else if (clk_en) begin
            if (sub_fall) begin
                // the fall cycle counts, so the length equals the pin spacing
                integ_ff     <= 1'b1;
                integ_cnt_ff <= 32'h1;
            end else if (v1_fall && integ_ff) begin
                integ_ff     <= 1'b0;
                integ_len_ff <= integ_cnt_ff;
            end else if (integ_ff) begin
                integ_cnt_ff <= integ_cnt_ff + 32'h1;
            end
        end
    end
endmodule : crts_sensor
`default_nettype wire

/* File: crts_gen.sv */
// generator end: frame, line and pixel sequencing of the sensor clocks
`timescale 1ns/1ps
`default_nettype none
module crts_gen
    import crts_pkg::*;
#(
    parameter int PIX_MIN_Q  = PIX_QUAD,     // pixels per line, quad
    parameter int PIX_MIN_S  = PIX_SINGLE,   // pixels per line, single
    parameter int LINE_MIN_Q = LINES_QUAD,   // lines per frame, quad
    parameter int LINE_MIN_S = LINES_SINGLE  // lines per frame, single
) (
    input  wire logic     mclk,        // system clock
    input  wire logic     sys_rst,     // sync reset, active high
    input  wire logic     clk_en,      // freezes all state when low
    input  wire logic     start,       // pulse: begin a frame
    input  wire logic     single_mode, // 1 single readout, 0 quad
    input  wire logic     shut_en,     // pulse substrate shutter first
    input  wire logic     dump_en,     // dump two lines per read line
    crts_if.gen           lnk,         // sensor clock pins
    output logic          busy_ff,     // frame in progress
    output logic          frame_done_ff// pulse: frame finished
);
    crts_state_t state_ff;
    logic [CNT_W-1:0] pix_ff;
    logic [CNT_W-1:0] line_ff;
    logic [CNT_W-1:0] pix_lim_ff;
    logic [CNT_W-1:0] line_lim_ff;
    logic [3:0]       sub_ff;
    logic [1:0]       dump_ff;
    logic             dump_mode_ff;
    logic             v1_ff;
    logic             v4_ff;
    logic             h_ff;
    logic             sub_pin_ff;
    logic             fdg_ff;
    logic             take_start;
    logic             shut_last;
    logic             vx_last;
    logic             px_last;
    logic             line_end;
    logic             frame_end;

    assign lnk.vertical_phase_one   = v1_ff;
    assign lnk.vertical_phase_four  = v4_ff;
    assign lnk.last_horizontal_gate = h_ff;
    assign lnk.sub_shutter          = sub_pin_ff;
    assign lnk.fast_dump_gate       = fdg_ff;

    // step decode, shared by both vertical phases
    function automatic logic at_step(input logic [CNT_W-1:0] cnt, input int n);
        return cnt == CNT_W'(n * VPH_CYC);
    endfunction : at_step

    // last line test; wraps like the counter itself, so limits stay below 2**CNT_W
    function automatic logic is_last_line(input logic [CNT_W-1:0] cnt,
                                          input logic [CNT_W-1:0] lim);
        return (cnt + CNT_W'(1)) >= lim;
    endfunction : is_last_line

    // sequencing events decoded once for all the blocks below
    assign take_start = (state_ff == CRTS_IDLE) && start;
    assign shut_last  = (state_ff == CRTS_SHUT) && (sub_ff == 4'(SHUT_CYC - 1));
    assign vx_last    = (state_ff == CRTS_VXFER) && at_step(pix_ff, 3);
    assign px_last    = (state_ff == CRTS_HREAD) && h_ff
                        && (pix_ff == pix_lim_ff - CNT_W'(1));
    assign line_end   = (state_ff == CRTS_DUMP) || px_last;
    assign frame_end  = line_end && is_last_line(line_ff, line_lim_ff);

    // frame state; a start in any other state is refused
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= CRTS_IDLE;
        end else if (clk_en) begin
            case (state_ff)
                CRTS_IDLE: begin
                    if (start) begin
                        state_ff <= shut_en ? CRTS_SHUT : CRTS_VXFER;
                    end
                end
                CRTS_SHUT: begin
                    if (shut_last) begin
                        state_ff <= CRTS_VXFER;
                    end
                end
                CRTS_VXFER: begin
                    // a dumped line needs no horizontal clocking
                    if (vx_last) begin
                        state_ff <= fdg_ff ? CRTS_DUMP : CRTS_HREAD;
                    end
                end
                CRTS_DUMP: begin
                    state_ff <= frame_end ? CRTS_IDLE : CRTS_VXFER;
                end
                CRTS_HREAD: begin
                    if (px_last) begin
                        state_ff <= frame_end ? CRTS_IDLE : CRTS_VXFER;
                    end
                end
                default: begin
                    state_ff <= CRTS_IDLE;
                end
            endcase
        end
    end

    // frame status seen by the host
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy_ff       <= 1'b0;
            frame_done_ff <= 1'b0;
        end else if (clk_en) begin
            frame_done_ff <= frame_end;
            if (take_start) begin
                busy_ff <= 1'b1;
            end else if (frame_end) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // mode limits latched at start, so input changes mid-frame are harmless
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_lim_ff   <= '0;
            line_lim_ff  <= '0;
            dump_mode_ff <= 1'b0;
        end else if (clk_en && take_start) begin
            pix_lim_ff   <= single_mode ? CNT_W'(PIX_MIN_S) : CNT_W'(PIX_MIN_Q);
            line_lim_ff  <= single_mode ? CNT_W'(LINE_MIN_S) : CNT_W'(LINE_MIN_Q);
            dump_mode_ff <= dump_en;
        end
    end

    // step and pixel counter, shared by transfer and readout to save a counter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_ff <= '0;
        end else if (clk_en) begin
            if (take_start || vx_last || px_last) begin
                pix_ff <= '0;
            end else if (state_ff == CRTS_VXFER || (state_ff == CRTS_HREAD && h_ff)) begin
                pix_ff <= pix_ff + CNT_W'(1);
            end
        end
    end

    // line counter; dumped lines count toward the frame length
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line_ff <= '0;
        end else if (clk_en) begin
            if (take_start) begin
                line_ff <= '0;
            end else if (line_end) begin
                line_ff <= line_ff + CNT_W'(1);
            end
        end
    end

    // substrate shutter pulse ahead of the first transfer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sub_ff     <= '0;
            sub_pin_ff <= 1'b0;
        end else if (clk_en) begin
            if (take_start) begin
                sub_ff     <= '0;
                sub_pin_ff <= shut_en;
            end else if (state_ff == CRTS_SHUT) begin
                sub_ff <= sub_ff + 4'h1;
                if (shut_last) begin
                    sub_pin_ff <= 1'b0;
                end
            end
        end
    end

    // dump pattern: two discarded lines, then one read line
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dump_ff <= '0;
            fdg_ff  <= 1'b0;
        end else if (clk_en) begin
            if (take_start) begin
                dump_ff <= '0;
            end else if (vx_last) begin
                dump_ff <= fdg_ff ? dump_ff + 2'h1 : 2'h0;
            end
            // gate stands across the whole transfer so the sensor sees it at the v1 fall
            if (state_ff == CRTS_VXFER) begin
                fdg_ff <= dump_mode_ff && (dump_ff != 2'(DUMP_LINES));
            end else if (state_ff == CRTS_DUMP) begin
                fdg_ff <= 1'b0;
            end
        end
    end

    // vertical phases; v4 rises with v1 high so its rising edge leads the v1 fall
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            v1_ff <= 1'b0;
            v4_ff <= 1'b0;
        end else if (clk_en && state_ff == CRTS_VXFER) begin
            if (at_step(pix_ff, 0)) begin
                v1_ff <= 1'b1;
            end else if (at_step(pix_ff, 1)) begin
                v4_ff <= 1'b1;
            end else if (at_step(pix_ff, 2)) begin
                v1_ff <= 1'b0;
            end else if (at_step(pix_ff, 3)) begin
                v4_ff <= 1'b0;
            end
        end
    end

    // horizontal gate: one period is two cycles, each fall moves one pixel
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            h_ff <= 1'b0;
        end else if (clk_en && state_ff == CRTS_HREAD) begin
            h_ff <= ~h_ff;
        end
    end
endmodule : crts_gen
`default_nettype wire

/* File: crts_monitor.sv */
// checker on the sensor clock pins between generator and sensor
`timescale 1ns/1ps
`default_nettype none
module crts_monitor (
    input wire logic mclk,                 // system clock
    input wire logic sys_rst,              // sync reset, active high
    input wire logic vertical_phase_one,   // pattern one pin
    input wire logic vertical_phase_four,  // pattern four pin
    input wire logic last_horizontal_gate, // pattern six pin
    input wire logic sub_shutter,          // substrate shutter pin
    input wire logic fast_dump_gate        // fast dump pin
);
    // one domain; delays assume clk_en stays high during frames
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // vertical steps are 4 cycles apart
    v4_lead_a: assert property ($rose(vertical_phase_one) |-> ##4 $rose(vertical_phase_four))
        else $error("phase four rise not 4 cycles after phase one rise");
    v1_fall_a: assert property ($rose(vertical_phase_four) |-> ##4 $fell(vertical_phase_one))
        else $error("phase one fall not led by phase four rise");
    // a pin dropped by reset is not a protocol edge
    v4_fall_a: assert property (!$past(sys_rst) && $fell(vertical_phase_one)
        |-> ##4 $fell(vertical_phase_four))
        else $error("phase four fall not 4 cycles after phase one fall");
    shut_pulse_a: assert property ($rose(sub_shutter) |-> sub_shutter[*4] ##1 !sub_shutter)
        else $error("shutter pulse not 4 cycles");
    // shutter ends before any row transfer starts integration window
    shut_clear_a: assert property (sub_shutter |-> !vertical_phase_one && !vertical_phase_four)
        else $error("shutter overlaps vertical transfer");
    gate_toggle_a: assert property ($rose(last_horizontal_gate) |=> $fell(last_horizontal_gate))
        else $error("horizontal gate high more than one cycle");
    gate_vert_a: assert property (vertical_phase_one || vertical_phase_four |-> !last_horizontal_gate)
        else $error("horizontal gate during vertical transfer");
    dump_hold_a: assert property ($rose(vertical_phase_one) && fast_dump_gate |-> fast_dump_gate[*8])
        else $error("dump gate dropped inside transfer");
    dump_nopix_a: assert property (fast_dump_gate |-> !last_horizontal_gate)
        else $error("pixels clocked on a dumped line");
    read_start_a: assert property (!$past(sys_rst) && $fell(vertical_phase_four)
        && !fast_dump_gate |-> ##[1:8] last_horizontal_gate)
        else $error("readout not started after transfer");
endmodule : crts_monitor
`default_nettype wire

/* File: crts_tb_top.sv */
// self-checking bench: generator and sensor joined over the pin interface
`timescale 1ns/1ps
`default_nettype none
module crts_tb_top;
    import crts_pkg::*;
    localparam int PQ = 6, PS = 8, LQ = 3, LS = 5;  // shortened counts
    logic mclk, sys_rst, clk_en, start, single_mode, shut_en, dump_en, busy, done;
    logic row_mv, pix_o, ln_dmp, integ, rst_q;
    logic [31:0] integ_len;
    logic [CNT_W-1:0] row_cnt, pix_cnt;
    logic [4:0] p1, p2, w;
    int n_mismatch, n_compared, cyc, rnd, m_row, m_pix, c_row, c_dmp, c_pix, n_done;
    logic e_row, e_dmp, e_pix, m_integ;
    crts_if lnk ();
    crts_gen #(.PIX_MIN_Q(PQ), .PIX_MIN_S(PS), .LINE_MIN_Q(LQ), .LINE_MIN_S(LS)) i_crts_gen (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .start(start),
        .single_mode(single_mode), .shut_en(shut_en), .dump_en(dump_en), .lnk(lnk),
        .busy_ff(busy), .frame_done_ff(done));
    crts_sensor i_crts_sensor (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .lnk(lnk), .row_moved_ff(row_mv),
        .pix_out_ff(pix_o), .line_dumped_ff(ln_dmp), .row_cnt_ff(row_cnt),
        .pix_cnt_ff(pix_cnt), .integ_ff(integ), .integ_len_ff(integ_len));
    crts_monitor i_crts_monitor (
        .mclk(mclk), .sys_rst(sys_rst), .vertical_phase_one(lnk.vertical_phase_one),
        .vertical_phase_four(lnk.vertical_phase_four), .sub_shutter(lnk.sub_shutter),
        .last_horizontal_gate(lnk.last_horizontal_gate), .fast_dump_gate(lnk.fast_dump_gate));
    assign w = {lnk.vertical_phase_one, lnk.vertical_phase_four, lnk.last_horizontal_gate,
                lnk.sub_shutter, lnk.fast_dump_gate};
    initial begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    function automatic int xs(input int x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    // hang guard, well above ten short frames
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    always @(posedge mclk) rst_q <= sys_rst;
    // pulses appear one cycle after the pin edge seen in p2 -> p1
    always @(negedge mclk) begin
        if (rst_q) begin
            p1 = 0; p2 = 0; m_row = 0; m_pix = 0; m_integ = 0;
        end else begin
            e_row = p2[4] & ~p1[4] & ~p1[0];
            e_dmp = p2[4] & ~p1[4] & p1[0];
            e_pix = p2[2] & ~p1[2];
            m_row += e_row;
            m_pix = (p2[4] & ~p1[4]) ? 0 : m_pix + e_pix;
            if (p2[1] & ~p1[1]) m_integ = 1;  // shutter fall wins a tie
            else if (p2[4] & ~p1[4]) m_integ = 0;
            chk({row_mv, ln_dmp, pix_o}, {e_row, e_dmp, e_pix});
            chk(integ, m_integ);
            chk(row_cnt, m_row);
            chk(pix_cnt, m_pix);
            c_row += row_mv;
            c_dmp += ln_dmp;
            c_pix += pix_o;
            n_done += done;
            p2 = p1;
            p1 = w;
        end
    end
    task automatic run_frame(input logic [2:0] k);
        int lines, dmp;
        {single_mode, shut_en, dump_en} = k;
        start = 1;
        @(negedge mclk);
        start = 0;
        c_row = 0; c_dmp = 0; c_pix = 0; n_done = 0;
        rnd = xs(rnd);
        repeat (rnd[3:0] + 2) @(negedge mclk);
        start = 1;  // refused while busy
        @(negedge mclk);
        start = 0;
        while (n_done == 0) @(negedge mclk);
        repeat (4) @(negedge mclk);
        lines = single_mode ? LS : LQ;
        dmp = 0;
        for (int j = 0; j < lines; j++) if (dump_en && j % 3 < 2) dmp++;
        chk(n_done, 1);
        chk(c_dmp, dmp);
        chk(c_row, lines - dmp);
        chk(c_pix, (lines - dmp) * (single_mode ? PS : PQ));
        chk(pix_cnt, (dump_en && (lines - 1) % 3 < 2) ? 0 : (single_mode ? PS : PQ));
        // shutter falls one cycle before the first step, v1 falls two steps later
        if (shut_en) chk(integ_len, 2 * VPH_CYC + 1);
        $display("frame mode %0d finished", k);
    endtask : run_frame
    initial begin
        sys_rst = 1; clk_en = 1; start = 0; single_mode = 0; shut_en = 0; dump_en = 0;
        rnd = 64;
        repeat (6) @(negedge mclk);
        sys_rst = 0;
        for (int i = 0; i < 8; i++) run_frame(i[2:0]);
        // start while frozen is ignored
        clk_en = 0;
        start = 1;
        @(negedge mclk);
        start = 0;
        clk_en = 1;
        repeat (2) @(negedge mclk);
        chk(busy, 0);
        $display("frozen start finished");
        // reset in mid frame clears pins and counters
        start = 1;
        @(negedge mclk);
        start = 0;
        repeat (30) @(negedge mclk);
        sys_rst = 1;
        @(negedge mclk);
        sys_rst = 0;
        chk({busy, w, row_cnt}, 0);
        $display("mid frame reset finished");
        run_frame(3'b111);
        complete_run();
    end
endmodule : crts_tb_top
`default_nettype wire
